//--- design/agt_map.svh
// Address map, field bounds and reset values of the gain tempco store.
// Assumes a 32-bit AHB-Lite bus; each register is one aligned word.
//
// Behaviour
// - 0x51 holds order-zero coefficient bits 7-0
// - 0x52 bits 6-0 hold order-zero bits 14-8
// - 0x52 bit 7 holds order-one bit 0
// - 0x53 holds order-one coefficient bits 8-1
// - 0x54 bits 4-0 hold order-one bits 13-9
// - 0x54 bits 7-5 hold order-two bits 2-0
// - 0x55 holds order-two coefficient bits 10-3
// - 0x56 bits 2-0 hold order-two bits 13-11
// - 0x56 bits 7-3 hold order-three bits 4-0
// - 0x57 bits 6-0 order-three 11-5, bit 7 spare
`ifndef AGT_MAP_SVH
`define AGT_MAP_SVH

// Register indices; byte address is four times the index
`define AGT_IDX_ORDER0_LOW 8'h51
`define AGT_IDX_ORDER0_HIGH 8'h52
`define AGT_IDX_ORDER1_MID 8'h53
`define AGT_IDX_ORDER1_HIGH_ORDER2_LOW 8'h54
`define AGT_IDX_ORDER2_MID 8'h55
`define AGT_IDX_ORDER2_HIGH_ORDER3_LOW 8'h56
`define AGT_IDX_ORDER3_HIGH 8'h57
`define AGT_COEF_BASE `AGT_IDX_ORDER0_LOW
`define AGT_COEF_COUNT 8'h07
`define AGT_IDX_CTRL 8'h60
`define AGT_IDX_STATUS 8'h61

// Index field of the byte address
`define AGT_IDX_MSB 9
`define AGT_IDX_LSB 2

// Coefficient widths
`define AGT_W_ORDER0 15
`define AGT_W_ORDER1 14
`define AGT_W_ORDER2 14
`define AGT_W_ORDER3 12
`define AGT_W_BYTE 8
`define AGT_W_IMAGE 56

// Control and status bits
`define AGT_CTRL_FREEZE 0
`define AGT_STAT_FROZEN 0
`define AGT_STAT_LOADED 1

`define AGT_RESET_BYTE 8'h00
`define AGT_RESET_WORD 32'h0000_0000
`define AGT_SPARE_BIT 1'b0

`endif

//--- design/agt_pkg.sv
// Types of the gain tempco store.
// Assumes agt_map.svh is on the include path.
`include "agt_map.svh"

package agt_pkg;

  // ==========================================================
  // Coefficient set
  typedef struct packed {
    logic [`AGT_W_ORDER3-1:0] gain_tempco_order3;
    logic [`AGT_W_ORDER2-1:0] gain_tempco_order2;
    logic [`AGT_W_ORDER1-1:0] gain_tempco_order1;
    logic [`AGT_W_ORDER0-1:0] gain_tempco_order0;
  } agt_coef_t;

  // ==========================================================
  // Captured address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [`AGT_IDX_MSB:`AGT_IDX_LSB] idx;
  } agt_aphase_t;

endpackage : agt_pkg

//--- design/agt_coef_store.sv
// Read-only store of the four gain temperature coefficients, AHB-Lite slave.
// Assumes coefficient values come from trim storage outside this clock
// domain and hold steady; they are synchronised before capture.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "agt_map.svh"

module agt_coef_store (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire agt_pkg::agt_coef_t trim_coef
);

  // ==========================================================
  // Packing: the seven bytes are one flat image, lowest weight first
  function automatic logic [`AGT_W_IMAGE-1:0] agt_pack(
    input agt_pkg::agt_coef_t c
  );
    agt_pack = {`AGT_SPARE_BIT, c};
  endfunction : agt_pack

  function automatic logic is_coef_idx(
    input logic [`AGT_IDX_MSB:`AGT_IDX_LSB] idx
  );
    is_coef_idx = (idx >= `AGT_COEF_BASE) &&
                  (idx < `AGT_COEF_BASE + `AGT_COEF_COUNT);
  endfunction : is_coef_idx

  // ==========================================================
  // Trim input synchroniser
  agt_pkg::agt_coef_t trim_s1_r;
  agt_pkg::agt_coef_t trim_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_s1_r <= '0;
      trim_s2_r <= '0;
    end else begin
      trim_s1_r <= trim_coef;
      trim_s2_r <= trim_s1_r;
    end
  end

  // ==========================================================
  // Control: freeze stops capture so reads see a stable set
  logic freeze_r;
  agt_pkg::agt_aphase_t aph_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freeze_r <= 1'b0;
    end else if (aph_r.valid && aph_r.write &&
                 aph_r.idx == `AGT_IDX_CTRL) begin
      freeze_r <= hwdata[`AGT_CTRL_FREEZE];
    end
  end

  // ==========================================================
  // Coefficient image; bus writes never reach it
  logic [`AGT_W_IMAGE-1:0] image_r;
  logic loaded_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image_r <= '0;
      loaded_r <= 1'b0;
    end else if (!freeze_r) begin
      image_r <= agt_pack(trim_s2_r);
      loaded_r <= 1'b1;
    end
  end

  // ==========================================================
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r <= '0;
    end else if (hready) begin
      aph_r.valid <= hsel && htrans[1];
      aph_r.write <= hwrite;
      aph_r.idx <= haddr[`AGT_IDX_MSB:`AGT_IDX_LSB];
    end
  end

  // ==========================================================
  // Read data, registered at the address phase for zero wait states
  logic [31:0] rdata_nxt;
  logic [7:0] byte_sel;

  always_comb begin
    byte_sel = haddr[`AGT_IDX_MSB:`AGT_IDX_LSB] - `AGT_COEF_BASE;
    rdata_nxt = `AGT_RESET_WORD;
    if (is_coef_idx(haddr[`AGT_IDX_MSB:`AGT_IDX_LSB])) begin
      rdata_nxt[`AGT_W_BYTE-1:0] =
        image_r[byte_sel[2:0]*`AGT_W_BYTE +: `AGT_W_BYTE];
    end else if (haddr[`AGT_IDX_MSB:`AGT_IDX_LSB] == `AGT_IDX_CTRL) begin
      rdata_nxt[`AGT_CTRL_FREEZE] = freeze_r;
    end else if (haddr[`AGT_IDX_MSB:`AGT_IDX_LSB] == `AGT_IDX_STATUS) begin
      rdata_nxt[`AGT_STAT_FROZEN] = freeze_r;
      rdata_nxt[`AGT_STAT_LOADED] = loaded_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `AGT_RESET_WORD;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rdata_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : agt_coef_store

//--- tb/agt_coef_store_props.sv
// Checker of the gain tempco store read port.
// Assumes trim_coef holds still around each read.
`timescale 1ns/1ps
module agt_coef_store_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire agt_pkg::agt_coef_t trim_coef
);
  logic [2:0] st;
  logic [55:0] w;
  logic [7:0] ix;
  logic rd;
  logic s;
  assign w = {1'b0, trim_coef};
  assign ix = haddr[9:2];
  assign rd = hsel & hready & htrans[1] & !hwrite;
  assign s = st == 3'h7;
  // Counts edges with the trim input unchanged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st <= 3'h0;
    else if (!$stable(trim_coef)) st <= 3'h0;
    else if (!s) st <= st + 3'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_b51; rd && ix == 8'h51 && s |=> hrdata == {24'h0, w[7:0]};
  endproperty
  a_b51: assert property (p_b51) else $error("byte 51 wrong");
  property p_b52; rd && ix == 8'h52 && s |=> hrdata[7:0] == w[15:8];
  endproperty
  a_b52: assert property (p_b52) else $error("byte 52 wrong");
  property p_b53; rd && ix == 8'h53 && s |=> hrdata[7:0] == w[23:16];
  endproperty
  a_b53: assert property (p_b53) else $error("byte 53 wrong");
  property p_b54; rd && ix == 8'h54 && s |=> hrdata[7:0] == w[31:24];
  endproperty
  a_b54: assert property (p_b54) else $error("byte 54 wrong");
  property p_b55; rd && ix == 8'h55 && s |=> hrdata[7:0] == w[39:32];
  endproperty
  a_b55: assert property (p_b55) else $error("byte 55 wrong");
  property p_b56; rd && ix == 8'h56 && s |=> hrdata[7:0] == w[47:40];
  endproperty
  a_b56: assert property (p_b56) else $error("byte 56 wrong");
  property p_b57; rd && ix == 8'h57 && s |=> hrdata == {24'h0, w[55:48]};
  endproperty
  a_b57: assert property (p_b57) else $error("byte 57 wrong");
  property p_ok; hreadyout && !hresp;
  endproperty
  a_ok: assert property (p_ok) else $error("bus answer wrong");
endmodule : agt_coef_store_props

//--- tb/tb.sv
// Bench of the gain tempco store: reads every coefficient byte.
// Assumes zero wait states; hready is fed from hreadyout.
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [55:0] img;
  agt_pkg::agt_coef_t trim;
  int err_count, compares;
  logic [15:0] rows [7] = '{16'h5171, 16'h5260, 16'h534F, 16'h543E,
    16'h552D, 16'h561C, 16'h575A};
  always #5 hclk = ~hclk;
  agt_coef_store u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .trim_coef(trim));
  task automatic conclude;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 99);
    if (n >= 99) begin
      err_count++;
      conclude;
    end
  endtask : wt
  task automatic bus(logic w, logic [7:0] ix, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask : bus
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    trim = 55'h5A1C2D3E4F6071;
    repeat (6) @(posedge hclk);
    chk("rst_rdata", 32'h0, hrdata);
    hresetn <= 1'b1;
    repeat (9) @(posedge hclk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i][15:8], 32'h0);
      chk("coef_byte", {24'h0, rows[i][7:0]}, q);
      img[i*8 +: 8] = q[7:0];
    end
    // Reassemble each coefficient from its slices, lowest weight last
    chk("tc0", {img[14:8], img[7:0]},
      trim.gain_tempco_order0);
    chk("tc1", {img[28:24], img[23:16], img[15]},
      trim.gain_tempco_order1);
    chk("tc2", {img[42:40], img[39:32], img[31:29]},
      trim.gain_tempco_order2);
    chk("tc3", {img[54:48], img[47:43]},
      trim.gain_tempco_order3);
    bus(1'b1, 8'h53, 32'hFF);
    bus(1'b0, 8'h53, 32'h0);
    chk("ro_write", 32'h4F, q);
    trim <= '1;
    repeat (9) @(posedge hclk);
    bus(1'b0, 8'h57, 32'h0);
    chk("spare", 32'h7F, q);
    bus(1'b0, 8'h52, 32'h0);
    chk("top_bit", 32'hFF, q);
    // Freeze holds the image while the trim input moves
    bus(1'b1, 8'h60, 32'h1);
    trim <= '0;
    repeat (4) @(posedge hclk);
    bus(1'b0, 8'h53, 32'h0);
    chk("frozen", 32'hFF, q);
    bus(1'b0, 8'h61, 32'h0);
    chk("status_frz", 32'h3, q);
    bus(1'b1, 8'h60, 32'h0);
    repeat (2) @(posedge hclk);
    bus(1'b0, 8'h53, 32'h0);
    chk("thawed", 32'h0, q);
    // Reset in mid-run clears read data and freeze
    bus(1'b1, 8'h60, 32'h1);
    bus(1'b0, 8'h60, 32'h0);
    chk("ctrl", 32'h1, q);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_mid", 32'h0, hrdata);
    hresetn <= 1'b1;
    repeat (9) @(posedge hclk);
    bus(1'b0, 8'h61, 32'h0);
    chk("status_rst", 32'h2, q);
    conclude;
  end
endmodule : tb
bind agt_coef_store agt_coef_store_props u_props (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .trim_coef);
